// *** rtl/vcc_pkg.sv ***
// Register map, field positions and reset values of the codec control register bank.
package vcc_pkg;
    localparam int unsigned REG_W = 8;
    localparam int unsigned NUM_REGS = 10;
    localparam logic [6:0] ADDR_MODE_POWER = 7'h00;
    localparam logic [6:0] ADDR_MODE_OUTCONV = 7'h01;
    localparam logic [6:0] ADDR_MODE_INPUT = 7'h02;
    localparam logic [6:0] ADDR_MODE_ANALOG = 7'h03;
    localparam logic [6:0] ADDR_GAIN_LOW = 7'h04;
    localparam logic [6:0] ADDR_GAIN_HIGH = 7'h05;
    localparam logic [6:0] ADDR_CLAMP_LEVEL = 7'h06;
    localparam logic [6:0] ADDR_CLAMP_TIMES = 7'h07;
    localparam logic [6:0] ADDR_FINE_CLAMP = 7'h08;
    localparam logic [6:0] ADDR_COARSE_CLAMP = 7'h09;
    localparam logic [6:0] ADDR_LAST = 7'h09;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Writable bits of each register; reserved bits are stored as zero.
    localparam logic [7:0] MASK_MODE_POWER = 8'h1f;
    localparam logic [7:0] MASK_MODE_ANALOG = 8'h3f;
    localparam logic [7:0] MASK_GAIN_HIGH = 8'h1f;
    localparam logic [7:0] MASK_CLAMP_LEVEL = 8'h7f;
    localparam logic [7:0] MASK_CLAMP_TIMES = 8'h7f;
    localparam logic [7:0] MASK_CLAMP_CTRL = 8'h3f;
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam int unsigned BIT_REF_SEL = 0;
    localparam int unsigned BIT_EXT_REF = 1;
    localparam int unsigned BIT_OUT_REF_PD = 2;
    localparam int unsigned BIT_VID_ADC_PD = 3;
    localparam int unsigned BIT_DEV_PD = 4;
    localparam int unsigned BIT_DUAL_EDGE = 4;
    localparam int unsigned BIT_TWO_CLOCK = 5;
    localparam int unsigned BIT_SUBSAMPLED = 6;
    localparam int unsigned BIT_INVERT = 7;
    localparam int unsigned BIT_CLAMP_HALF = 0;
    localparam int unsigned BIT_DIFF_IN = 1;
    localparam int unsigned BIT_SHA_GAIN2 = 2;
    localparam int unsigned BIT_VOLT_CLAMP = 3;
    localparam int unsigned BIT_TRISTATE = 4;
    localparam int unsigned BIT_SYNC_POL = 5;
    localparam int unsigned BIT_GAIN_SYNC = 4;
    localparam int unsigned BIT_CLAMP_SYNC = 6;
    localparam int unsigned POS_FINE_TIME = 0;
    localparam int unsigned POS_COARSE_TIME = 3;
    localparam int unsigned NUM_CLAMPS = 3;
    localparam int unsigned TIME_W = 3;
    localparam int unsigned GAIN_W = 12;
    localparam int unsigned GAIN_INT_W = 3;
    localparam int unsigned GAIN_FRAC_W = 9;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 12'h000;
endpackage

// *** rtl/vcc_regs.sv ***
// Control register bank of the codec, reached through the register pointer.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------------------
module vcc_regs
    import vcc_pkg::*;
#(
    parameter int unsigned CLAMP_TIME_W = TIME_W
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic bus_start,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_rd,
    output logic bus_ack,
    output logic [7:0] bus_rdata,
    input wire logic sync_in,
    output logic reference_level_select,
    output logic external_reference_enable,
    output logic output_reference_powerdown,
    output logic video_converter_powerdown,
    output logic device_powerdown,
    output logic [3:0] converter_powerdown,
    output logic dual_edge_capture,
    output logic two_clock_capture,
    output logic chroma_subsampled_input,
    output logic converter_input_invert,
    output logic [3:0] input_config,
    output logic [2:0] sha_powerdown,
    output logic aux_converter_powerdown,
    output logic clamp_current_half,
    output logic differential_input,
    output logic sha_gain_two,
    output logic voltage_clamp_enable,
    output logic output_tristate,
    output logic sync_polarity_select,
    output logic [GAIN_W-1:0] gain_multiplier,
    output logic [GAIN_INT_W-1:0] gain_integer,
    output logic [GAIN_FRAC_W-1:0] gain_fraction,
    output logic [6:0] clamp_black_level,
    output logic [NUM_CLAMPS-1:0] fine_clamp_on,
    output logic [NUM_CLAMPS-1:0] fine_clamp_up,
    output logic [NUM_CLAMPS-1:0] coarse_clamp_on,
    output logic [NUM_CLAMPS-1:0] coarse_clamp_up
);

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    // Writable-bit mask per address; used by the write path.
    function automatic logic [7:0] wmask(input logic [6:0] a);
        logic [7:0] m;
        m = MASK_FULL;
        unique case (a)
            ADDR_MODE_POWER: m = MASK_MODE_POWER;
            ADDR_MODE_ANALOG: m = MASK_MODE_ANALOG;
            ADDR_GAIN_HIGH: m = MASK_GAIN_HIGH;
            ADDR_CLAMP_LEVEL: m = MASK_CLAMP_LEVEL;
            ADDR_CLAMP_TIMES: m = MASK_CLAMP_TIMES;
            ADDR_FINE_CLAMP: m = MASK_CLAMP_CTRL;
            ADDR_COARSE_CLAMP: m = MASK_CLAMP_CTRL;
            default: m = MASK_FULL;
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------------------
    // Pointer and register file
    // ------------------------------------------------------------------------
    logic [7:0] regs_q [NUM_REGS];
    logic [7:0] register_pointer_q;
    logic [6:0] addr;
    logic addr_ok;
    logic data_wr;
    logic wr_hit;
    logic [NUM_REGS-1:0] wr_sel;

    assign addr = register_pointer_q[6:0];
    assign addr_ok = (addr <= ADDR_LAST);
    assign data_wr = bus_wr && !bus_start;
    assign wr_hit = clk_en && data_wr && addr_ok;
    // A write past the last register is refused and stores nothing.
    assign bus_ack = (bus_start && bus_wr) || (data_wr && addr_ok) || bus_rd;

    // Pointer loads on the first byte of an access and then steps per byte, holding once past the last register (reads hold at the last).
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            register_pointer_q <= REG_RESET;
        else if (clk_en && bus_start && bus_wr)
            register_pointer_q <= {1'b0, bus_wdata[6:0]};
        else if (clk_en && ((data_wr && addr_ok) || (bus_rd && addr < ADDR_LAST)))
            register_pointer_q <= register_pointer_q + 8'h01;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++)
        begin : g_reg
            assign wr_sel[gi] = wr_hit && (addr == 7'(gi));
            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                    regs_q[gi] <= REG_RESET;
                else if (wr_sel[gi])
                    regs_q[gi] <= bus_wdata & wmask(7'(gi));
            end
        end
    endgenerate

    // Reads past the last register keep returning the last one.
    logic [6:0] rd_addr;
    assign rd_addr = addr_ok ? addr : ADDR_LAST;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            bus_rdata <= REG_RESET;
        else if (clk_en)
            bus_rdata <= regs_q[rd_addr[3:0]];
    end

    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    logic [7:0] mp, mo, mi, ma;
    assign mp = regs_q[ADDR_MODE_POWER[3:0]];
    assign mo = regs_q[ADDR_MODE_OUTCONV[3:0]];
    assign mi = regs_q[ADDR_MODE_INPUT[3:0]];
    assign ma = regs_q[ADDR_MODE_ANALOG[3:0]];

    assign reference_level_select = mp[BIT_REF_SEL];
    assign external_reference_enable = mp[BIT_EXT_REF];
    assign output_reference_powerdown = mp[BIT_OUT_REF_PD];
    assign video_converter_powerdown = mp[BIT_VID_ADC_PD];
    assign device_powerdown = mp[BIT_DEV_PD];
    assign converter_powerdown = mo[3:0];
    assign dual_edge_capture = mo[BIT_DUAL_EDGE];
    assign two_clock_capture = mo[BIT_TWO_CLOCK];
    // The subsampled format is suppressed while either clocking mode is on.
    assign chroma_subsampled_input = mo[BIT_SUBSAMPLED] && !mo[BIT_DUAL_EDGE]
        && !mo[BIT_TWO_CLOCK];
    assign converter_input_invert = mo[BIT_INVERT];
    assign input_config = mi[3:0];
    assign sha_powerdown = mi[6:4];
    assign aux_converter_powerdown = mi[7];
    assign clamp_current_half = ma[BIT_CLAMP_HALF];
    assign differential_input = ma[BIT_DIFF_IN];
    assign sha_gain_two = ma[BIT_SHA_GAIN2];
    assign voltage_clamp_enable = ma[BIT_VOLT_CLAMP];
    assign output_tristate = ma[BIT_TRISTATE];
    assign sync_polarity_select = ma[BIT_SYNC_POL];
    assign clamp_black_level = regs_q[ADDR_CLAMP_LEVEL[3:0]][6:0];

    // ------------------------------------------------------------------------
    // Sync detection
    // ------------------------------------------------------------------------
    logic sync_act, sync_prev_q, sync_edge;
    assign sync_act = sync_polarity_select ? sync_in : !sync_in;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sync_prev_q <= 1'b0;
        else if (clk_en)
            sync_prev_q <= sync_act;
    end
    assign sync_edge = sync_act && !sync_prev_q;

    // ------------------------------------------------------------------------
    // Gain multiplier
    // ------------------------------------------------------------------------
    // The low byte alone never changes the applied gain, so software can
    // update both halves without a glitch in between.
    logic [GAIN_W-1:0] gain_pend_q, gain_q;
    logic gain_wait_q, gain_hi_wr;
    logic [7:0] gh;
    assign gh = bus_wdata & MASK_GAIN_HIGH;
    assign gain_hi_wr = wr_sel[ADDR_GAIN_HIGH[3:0]];
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            gain_pend_q <= GAIN_RESET;
            gain_q <= GAIN_RESET;
            gain_wait_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (gain_hi_wr && !gh[BIT_GAIN_SYNC])
            begin
                gain_q <= {gh[3:0], regs_q[ADDR_GAIN_LOW[3:0]]};
                gain_wait_q <= 1'b0;
            end
            else if (gain_hi_wr)
            begin
                gain_pend_q <= {gh[3:0], regs_q[ADDR_GAIN_LOW[3:0]]};
                gain_wait_q <= 1'b1;
            end
            else if (gain_wait_q && sync_edge)
            begin
                gain_q <= gain_pend_q;
                gain_wait_q <= 1'b0;
            end
        end
    end
    assign gain_multiplier = gain_q;
    assign gain_integer = gain_q[GAIN_W-1 -: GAIN_INT_W];
    assign gain_fraction = gain_q[GAIN_FRAC_W-1:0];

    // ------------------------------------------------------------------------
    // Clamp timers
    // ------------------------------------------------------------------------
    logic [7:0] ct, fc, cc;
    logic clamp_sync;
    logic [CLAMP_TIME_W-1:0] fine_time, coarse_time;
    assign ct = regs_q[ADDR_CLAMP_TIMES[3:0]];
    assign fc = regs_q[ADDR_FINE_CLAMP[3:0]];
    assign cc = regs_q[ADDR_COARSE_CLAMP[3:0]];
    assign clamp_sync = ct[BIT_CLAMP_SYNC];
    assign fine_time = ct[POS_FINE_TIME +: TIME_W];
    assign coarse_time = ct[POS_COARSE_TIME +: TIME_W];

    logic [2*NUM_CLAMPS-1:0] on_bits, up_bits, on_prev_q, arm_q, run;
    logic [CLAMP_TIME_W-1:0] cnt_q [2*NUM_CLAMPS];
    generate
        for (gi = 0; gi < NUM_CLAMPS; gi++)
        begin : g_map
            assign on_bits[gi] = fc[2*gi+1];
            assign up_bits[gi] = fc[2*gi];
            assign on_bits[NUM_CLAMPS+gi] = cc[2*gi+1];
            assign up_bits[NUM_CLAMPS+gi] = cc[2*gi];
        end
        for (gi = 0; gi < 2*NUM_CLAMPS; gi++)
        begin : g_clamp
            logic rise, fire;
            logic [CLAMP_TIME_W-1:0] dur;
            assign dur = (gi < NUM_CLAMPS) ? fine_time : coarse_time;
            assign rise = on_bits[gi] && !on_prev_q[gi];
            // Armed clamps fire at once, or at the next sync edge in sync mode.
            assign fire = (rise || arm_q[gi]) && (!clamp_sync || sync_edge);
            assign run[gi] = (cnt_q[gi] != '0);
            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                begin
                    on_prev_q[gi] <= 1'b0;
                    arm_q[gi] <= 1'b0;
                    cnt_q[gi] <= '0;
                end
                else if (clk_en)
                begin
                    on_prev_q[gi] <= on_bits[gi];
                    arm_q[gi] <= (rise || arm_q[gi]) && !fire && on_bits[gi];
                    if (fire)
                        cnt_q[gi] <= dur;
                    else if (run[gi])
                        cnt_q[gi] <= cnt_q[gi] - 1'b1;
                end
            end
        end
    endgenerate
    assign fine_clamp_on = run[NUM_CLAMPS-1:0];
    assign coarse_clamp_on = run[2*NUM_CLAMPS-1:NUM_CLAMPS];
    // Direction is only meaningful while the clamp runs.
    assign fine_clamp_up = up_bits[NUM_CLAMPS-1:0] & run[NUM_CLAMPS-1:0];
    assign coarse_clamp_up = up_bits[2*NUM_CLAMPS-1:NUM_CLAMPS]
        & run[2*NUM_CLAMPS-1:NUM_CLAMPS];

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_pointer_top_zero: assert property (@(posedge clock) disable iff (rst)
        register_pointer_q[7] == 1'b0) else $error("pointer top bit set");
    a_pointer_load: assert property (@(posedge clock) disable iff (rst)
        clk_en && bus_start && bus_wr |=> addr == $past(bus_wdata[6:0]))
        else $error("pointer not loaded");
    a_pointer_step: assert property (@(posedge clock) disable iff (rst)
        clk_en && data_wr && addr_ok |=> addr == $past(addr) + 7'h01)
        else $error("pointer did not advance");
    a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
        mp[7:5] == 3'h0 && ma[7:6] == 2'h0 && regs_q[ADDR_GAIN_HIGH[3:0]][7:5] == 3'h0)
        else $error("reserved bit stored");
    a_subsampled_gate: assert property (@(posedge clock) disable iff (rst)
        (dual_edge_capture || two_clock_capture) |-> !chroma_subsampled_input)
        else $error("subsampled with dual clocking");
    a_gain_low_only: assert property (@(posedge clock) disable iff (rst)
        clk_en && !gain_hi_wr && !(gain_wait_q && sync_edge) |=> $stable(gain_q))
        else $error("gain changed without high write");
    a_gain_apply: assert property (@(posedge clock) disable iff (rst)
        clk_en && gain_hi_wr && !gh[BIT_GAIN_SYNC] |=>
        gain_q == {$past(gh[3:0]), $past(regs_q[ADDR_GAIN_LOW[3:0]])})
        else $error("gain not applied");
    a_gain_waits: assert property (@(posedge clock) disable iff (rst)
        gain_wait_q && !sync_edge && !gain_hi_wr ##1 clk_en |-> $stable(gain_q))
        else $error("gain applied before sync");
    a_clamp_retrig: assert property (@(posedge clock) disable iff (rst)
        clk_en && on_prev_q[0] && on_bits[0] && !arm_q[0] && !run[0] |=> !run[0])
        else $error("clamp fired without new edge");
    a_clamp_sync: assert property (@(posedge clock) disable iff (rst)
        clk_en && clamp_sync && !sync_edge && !run[0] |=> !run[0])
        else $error("clamp fired without sync");
    a_clamp_time: assert property (@(posedge clock) disable iff (rst)
        clk_en && !clamp_sync && on_bits[0] && !on_prev_q[0] |=>
        cnt_q[0] == $past(fine_time)) else $error("fine clamp time wrong");

endmodule // vcc_regs
`default_nettype wire

// *** verification/vcc_host_model.sv ***
// Host processor model that moves bytes through the register byte port.
`timescale 1ns/1ps
`default_nettype none
module vcc_host_model
    import vcc_pkg::*;
(
    input wire logic clock,
    input wire logic bus_ack,
    input wire logic [7:0] bus_rdata,
    output logic bus_start,
    output logic bus_wr,
    output logic bus_rd,
    output logic [7:0] bus_wdata
);
    logic [7:0] data_q [0:15];
    logic ack_seen;
    initial
    begin
        bus_start = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_wdata = 8'h00;
    end
    // ------------------------------------------------------------------------
    // Byte cycles
    // ------------------------------------------------------------------------
    // Called on a rising edge; the byte stands until the next edge, where the design
    // takes it and the acknowledge is sampled.
    task automatic drive(input logic s, input logic w, input logic r, input logic [7:0] d);
        bus_start <= s;
        bus_wr <= w;
        bus_rd <= r;
        bus_wdata <= d;
        @(posedge clock);
        ack_seen = bus_ack;
    endtask
    // An idle data line shows the inverse of its last byte so a stale copy is never taken.
    task automatic idle();
        drive(1'b0, 1'b0, 1'b0, ~bus_wdata);
    endtask
    task automatic point(input logic [6:0] a, output logic [7:0] d);
        drive(1'b1, 1'b1, 1'b0, {1'b0, a});
        idle();
        idle();
        d = bus_rdata;
    endtask
    task automatic rd_next(output logic [7:0] d);
        drive(1'b0, 1'b0, 1'b1, ~bus_wdata);
        idle();
        idle();
        d = bus_rdata;
    endtask
    task automatic burst(input logic [6:0] a, input int n, output logic last_ack);
        drive(1'b1, 1'b1, 1'b0, {1'b0, a});
        for (int i = 0; i < n; i++)
            drive(1'b0, 1'b1, 1'b0, data_q[i]);
        last_ack = ack_seen;
        idle();
        idle();
    endtask
endmodule // vcc_host_model
`default_nettype wire

// *** verification/vcc_regs_test.sv ***
// Self-checking bench of the codec control register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module vcc_regs_test
    import vcc_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic sync_in = 1'b1;
    logic bus_start, bus_wr, bus_rd, bus_ack;
    logic [7:0] bus_wdata, bus_rdata;
    logic reference_level_select, external_reference_enable, output_reference_powerdown;
    logic video_converter_powerdown, device_powerdown, dual_edge_capture, two_clock_capture;
    logic chroma_subsampled_input, converter_input_invert, aux_converter_powerdown;
    logic clamp_current_half, differential_input, sha_gain_two, voltage_clamp_enable;
    logic output_tristate, sync_polarity_select;
    logic [3:0] converter_powerdown, input_config;
    logic [2:0] sha_powerdown, gain_integer;
    logic [11:0] gain_multiplier;
    logic [8:0] gain_fraction;
    logic [6:0] clamp_black_level;
    logic [2:0] fine_clamp_on, fine_clamp_up, coarse_clamp_on, coarse_clamp_up;
    logic [7:0] e [0:9] = '{default: 8'h00};
    logic [31:0] rnd = 32'h4384a8ad;
    int fail_count = 0;
    int check_count = 0;
    int fine_n = 0;
    int coarse_n = 0;
    int up_n = 0;
    wire [4:0] out_m0 = {device_powerdown, video_converter_powerdown,
        output_reference_powerdown, external_reference_enable, reference_level_select};
    wire [7:0] out_m1 = {converter_input_invert, chroma_subsampled_input, two_clock_capture,
        dual_edge_capture, converter_powerdown};
    wire [7:0] out_m2 = {aux_converter_powerdown, sha_powerdown, input_config};
    wire [5:0] out_m3 = {sync_polarity_select, output_tristate, voltage_clamp_enable,
        sha_gain_two, differential_input, clamp_current_half};
    vcc_regs vcc_regs_i (.clock, .rst, .clk_en, .bus_start, .bus_wr, .bus_wdata, .bus_rd,
        .bus_ack, .bus_rdata, .sync_in, .reference_level_select, .external_reference_enable,
        .output_reference_powerdown, .video_converter_powerdown, .device_powerdown,
        .converter_powerdown, .dual_edge_capture, .two_clock_capture, .chroma_subsampled_input,
        .converter_input_invert, .input_config, .sha_powerdown, .aux_converter_powerdown,
        .clamp_current_half, .differential_input, .sha_gain_two, .voltage_clamp_enable,
        .output_tristate, .sync_polarity_select, .gain_multiplier, .gain_integer,
        .gain_fraction, .clamp_black_level, .fine_clamp_on, .fine_clamp_up,
        .coarse_clamp_on, .coarse_clamp_up);
    vcc_host_model vcc_host_model_i (.clock, .bus_ack, .bus_rdata, .bus_start, .bus_wr,
        .bus_rd, .bus_wdata);
    always #2 clock = ~clock;
    always @(posedge clock)
    begin
        fine_n += int'(fine_clamp_on[0] === 1'b1);
        coarse_n += int'(coarse_clamp_on[0] === 1'b1);
        up_n += int'(fine_clamp_up[0] === 1'b1);
    end
    // ------------------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction
    // The gain sync-wait bit is kept clear here so random gain takes effect at once.
    function automatic logic [7:0] legal(input int a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == 0) ? MASK_MODE_POWER : (a == 3) ? MASK_MODE_ANALOG :
            (a == 5) ? (MASK_GAIN_HIGH & 8'hef) : (a == 6) ? MASK_CLAMP_LEVEL :
            (a == 7) ? MASK_CLAMP_TIMES : (a >= 8) ? MASK_CLAMP_CTRL : MASK_FULL;
        legal = d & m;
        if (a == 1 && legal[6])
            legal[5:4] = 2'b00;
    endfunction
    task automatic read_all();
        logic [7:0] d;
        vcc_host_model_i.point(7'h00, d);
        for (int a = 0; a < 11; a++)
        begin
            `CHK("reg_read", e[(a < 10) ? a : 9], d)
            vcc_host_model_i.rd_next(d);
        end
    endtask
    task automatic chk_out();
        `CHK("mode_power", e[0][4:0], out_m0)
        `CHK("mode_conv", e[1], out_m1)
        `CHK("mode_input", e[2], out_m2)
        `CHK("mode_analog", e[3][5:0], out_m3)
        `CHK("black_level", e[6][6:0], clamp_black_level)
        `CHK("gain", {e[5][3:0], e[4]}, gain_multiplier)
        `CHK("gain_int", e[5][3:1], gain_integer)
        `CHK("gain_frac", {e[5][0], e[4]}, gain_fraction)
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    initial
    begin
        #20000;
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        logic ack;
        int f0, c0, u0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        read_all();
        chk_out();
        for (int k = 0; k < 4; k++)
        begin
            for (int a = 0; a < 11; a++)
            begin
                rnd = xs(rnd);
                vcc_host_model_i.data_q[a] = legal(a, rnd[7:0]);
                if (a < 10)
                    e[a] = vcc_host_model_i.data_q[a];
            end
            vcc_host_model_i.burst(7'h00, 11, ack);
            `CHK("ack_past_last", 1'b0, ack)
            read_all();
            chk_out();
        end
        rnd = xs(rnd);
        vcc_host_model_i.data_q[0] = rnd[7:0];
        vcc_host_model_i.burst(ADDR_GAIN_LOW, 1, ack);
        `CHK("gain_held", {e[5][3:0], e[4]}, gain_multiplier)
        e[4] = rnd[7:0];
        e[5] = {4'h0, rnd[11:8]};
        vcc_host_model_i.data_q[0] = e[5];
        vcc_host_model_i.burst(ADDR_GAIN_HIGH, 1, ack);
        `CHK("gain_new", {e[5][3:0], e[4]}, gain_multiplier)
        for (int p = 0; p < 2; p++)
        begin
            sync_in <= ~p[0];
            vcc_host_model_i.data_q[0] = {2'b00, p[0], 5'h00};
            vcc_host_model_i.data_q[1] = 8'h00;
            vcc_host_model_i.burst(ADDR_MODE_ANALOG, 1, ack);
            vcc_host_model_i.data_q[0] = 8'h00;
            vcc_host_model_i.burst(ADDR_FINE_CLAMP, 2, ack);
            rnd = xs(rnd);
            vcc_host_model_i.data_q[0] = rnd[7:0];
            vcc_host_model_i.data_q[1] = {4'h1, rnd[11:8]};
            vcc_host_model_i.burst(ADDR_GAIN_LOW, 2, ack);
            vcc_host_model_i.data_q[0] = {2'b01, 3'(2 + p), 3'(3 + p)};
            vcc_host_model_i.data_q[1] = 8'h03;
            vcc_host_model_i.data_q[2] = 8'h03;
            f0 = fine_n;
            c0 = coarse_n;
            u0 = up_n;
            vcc_host_model_i.burst(ADDR_CLAMP_TIMES, 3, ack);
            repeat (6) @(posedge clock);
            `CHK("clamp_wait", 0, fine_n - f0 + coarse_n - c0)
            `CHK("gain_wait", {e[5][3:0], e[4]}, gain_multiplier)
            sync_in <= p[0];
            repeat (2) @(posedge clock);
            `CHK("clamp_vec", {4{3'b001}}, {fine_clamp_on, fine_clamp_up, coarse_clamp_on, coarse_clamp_up})
            sync_in <= ~p[0];
            repeat (12) @(posedge clock);
            e[4] = rnd[7:0];
            e[5] = {4'h1, rnd[11:8]};
            `CHK("gain_sync", {e[5][3:0], e[4]}, gain_multiplier)
            `CHK("fine_time", 3 + p, fine_n - f0)
            `CHK("fine_dir", 3 + p, up_n - u0)
            `CHK("coarse_time", 2 + p, coarse_n - c0)
        end
        vcc_host_model_i.data_q[0] = 8'h05;
        vcc_host_model_i.data_q[1] = 8'h03;
        f0 = fine_n;
        vcc_host_model_i.burst(ADDR_CLAMP_TIMES, 2, ack);
        repeat (10) @(posedge clock);
        `CHK("no_retrigger", 0, fine_n - f0)
        vcc_host_model_i.data_q[0] = 8'h01;
        vcc_host_model_i.burst(ADDR_FINE_CLAMP, 1, ack);
        vcc_host_model_i.data_q[0] = 8'h03;
        f0 = fine_n;
        vcc_host_model_i.burst(ADDR_FINE_CLAMP, 1, ack);
        repeat (10) @(posedge clock);
        `CHK("retrigger", 5, fine_n - f0)
        // With the clock enable low a write must leave the mode bits untouched.
        clk_en <= 1'b0;
        vcc_host_model_i.data_q[0] = ~e[0] & MASK_MODE_POWER;
        vcc_host_model_i.burst(ADDR_MODE_POWER, 1, ack);
        `CHK("freeze", e[0][4:0], out_m0)
        clk_en <= 1'b1;
        for (int v = 0; v < 2; v++)
        begin
            vcc_host_model_i.data_q[0] = v ? 8'h40 : 8'h70;
            vcc_host_model_i.burst(ADDR_MODE_OUTCONV, 1, ack);
            `CHK("ack_data", 1'b1, ack)
            `CHK("subsampled", v[0], chroma_subsampled_input)
        end
        report_and_stop();
    end
endmodule // vcc_regs_test
`default_nettype wire
